//--- design/scb_map.svh
/*
 Timing counts, commands and widths for the configuration loader.
 Assumes inclusion by bare name; definitions only.
*/
`ifndef SCB_MAP_SVH
`define SCB_MAP_SVH
// Clock rate in kHz and the least wake-up wait in microseconds.
`define SCB_CLK_KHZ 20000
`define SCB_WAKE_US 30
// Least wait in cycles, rounded up.
`define SCB_WAKE_CYC ((`SCB_WAKE_US * `SCB_CLK_KHZ + 999) / 1000)
// Flash instructions and start address.
`define SCB_CMD_WAKE 8'h_AB
`define SCB_CMD_FAST 8'h_0B
`define SCB_ADDR_START 24'h_0000_00
// Serial clock divider: half period in system cycles.
`define SCB_SCK_HALF 2
// Dummy cycles after the fast read address.
`define SCB_DUMMY_BITS 8
// Mode codes on the mode pins.
`define SCB_MODE_ACTIVE 2'h_0
`define SCB_MODE_PASSIVE 2'h_1
`define SCB_MODE_JTAG 2'h_2
// Bus widths in active mode.
`define SCB_W_X1 2'h_0
`define SCB_W_X2 2'h_1
`define SCB_W_X4 2'h_2
`endif

//--- design/scb_pkg.sv
/*
 Types shared by the configuration loader files.
 Assumes scb_map.svh constants are used alongside.
*/
package scb_pkg;
   typedef enum logic [1:0] {
      SCB_ACTIVE,
      SCB_PASSIVE,
      SCB_JTAG,
      SCB_NONE
   } scb_mode_t;

   typedef struct packed {
      logic [7:0] data;
      logic valid;
   } scb_byte_t;
endpackage

//--- design/scb_fifo.sv
/*
 Small first-in first-out buffer with valid and ready on both sides.
 Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/10ps
module scb_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wr_reg;
   logic [AW-1:0] rd_reg;
   logic [AW:0] cnt_reg;
   logic push;
   logic pop;

   assign o_in_ready = (cnt_reg != (AW+1)'(DEPTH));
   assign o_out_valid = (cnt_reg != '0);
   assign o_out_data = mem_reg[rd_reg];
   assign push = i_in_valid & o_in_ready;
   assign pop = o_out_valid & i_out_ready;

   always_ff @(posedge i_clk) begin
      if (push) begin
         mem_reg[wr_reg] <= i_in_data;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end else begin
         if (push) begin
            wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
         end
         if (pop) begin
            rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
         end
         cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // scb_fifo

//--- design/scb_loader.sv
/*
 Configuration loader: fills the configuration memory from a bitstream.
 Assumes a 20 MHz system clock; all pins but I_RAM_READY arrive asynchronous.
*/
`timescale 1ns/10ps
`include "scb_map.svh"
module scb_loader #(
   parameter int IMAGE_BYTES = 16,
   parameter int WAKE_CYC = `SCB_WAKE_CYC,
   parameter int FIFO_DEPTH = 8
) (
   input wire logic I_CLK_SYS,
   input wire logic I_RESET_N,
   input wire logic I_CONFIG_RESET_N,
   input wire logic [1:0] I_MODE,
   input wire logic [1:0] I_WIDTH,
   input wire logic I_MULTI_IMAGE,
   input wire logic [3:0] I_FLASH_DQ,
   input wire logic I_PASSIVE_SCK,
   input wire logic I_PASSIVE_DATA,
   input wire logic I_TEST_VALID,
   input wire logic [7:0] I_TEST_DATA,
   input wire logic I_RAM_READY,
   output logic O_FLASH_SCK,
   output logic O_FLASH_CS_N,
   output logic O_FLASH_MOSI,
   output logic O_FLASH_MOSI_OE_N,
   output logic O_RAM_WE,
   output logic [7:0] O_RAM_DATA,
   output logic O_DONE,
   output logic O_ERROR
);
   typedef enum logic [3:0] {
      ST_IDLE, ST_WAKE, ST_WAIT, ST_CMD, ST_DUMMY, ST_DATA, ST_PASS,
      ST_DONE, ST_ERR
   } st_t;

   st_t st_reg;
   logic [2:0] crn_sync_reg;
   logic [2:0] psck_sync_reg;
   logic [1:0] pdat_sync_reg;
   logic [7:0] dq_sync1_reg;
   logic [3:0] dq_sync2_reg;
   logic [1:0] mode_sync1_reg;
   logic [1:0] mode_reg;
   logic [1:0] width_sync1_reg;
   logic [1:0] width_reg;
   logic [1:0] multi_sync_reg;
   logic [1:0] tv_sync_reg;
   logic tv_prev_reg;
   logic [7:0] td_sync1_reg;
   logic [7:0] td_reg;
   logic [1:0] div_reg;
   logic sck_reg;
   logic [31:0] sh_out_reg;
   logic [5:0] bits_reg;
   logic [15:0] wait_reg;
   logic [7:0] sh_in_reg;
   logic [3:0] nbits_reg;
   logic [31:0] bytes_reg;
   logic byte_vld_reg;
   logic [7:0] byte_reg;
   logic f_ready;
   logic f_valid;
   logic [7:0] f_data;
   logic crn_rise;
   logic psck_rise;
   logic tick_fall;
   logic tick_rise;
   scb_pkg::scb_byte_t in_byte;

   // Bits captured per serial clock rise for a given width.
   function automatic logic [3:0] step_bits(input logic [1:0] w);
      unique case (w)
         `SCB_W_X2: step_bits = 4'h_2;
         `SCB_W_X4: step_bits = 4'h_4;
         default: step_bits = 4'h_1;
      endcase
   endfunction

   // ------------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------------
   always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         crn_sync_reg <= '1;
         psck_sync_reg <= '0;
         pdat_sync_reg <= '0;
         dq_sync1_reg <= '0;
         dq_sync2_reg <= '0;
         mode_sync1_reg <= '0;
         mode_reg <= '0;
         width_sync1_reg <= '0;
         width_reg <= '0;
         multi_sync_reg <= '0;
         tv_sync_reg <= '0;
         tv_prev_reg <= 1'b0;
         td_sync1_reg <= '0;
         td_reg <= '0;
      end else begin
         crn_sync_reg <= {crn_sync_reg[1:0], I_CONFIG_RESET_N};
         psck_sync_reg <= {psck_sync_reg[1:0], I_PASSIVE_SCK};
         pdat_sync_reg <= {pdat_sync_reg[0], I_PASSIVE_DATA};
         dq_sync1_reg <= {4'h_0, I_FLASH_DQ};
         dq_sync2_reg <= dq_sync1_reg[3:0];
         mode_sync1_reg <= I_MODE;
         mode_reg <= mode_sync1_reg;
         width_sync1_reg <= I_WIDTH;
         width_reg <= width_sync1_reg;
         multi_sync_reg <= {multi_sync_reg[0], I_MULTI_IMAGE};
         tv_sync_reg <= {tv_sync_reg[0], I_TEST_VALID};
         tv_prev_reg <= tv_sync_reg[1];
         td_sync1_reg <= I_TEST_DATA;
         td_reg <= td_sync1_reg;
      end
   end

   assign crn_rise = crn_sync_reg[1] & ~crn_sync_reg[2];
   assign psck_rise = psck_sync_reg[1] & ~psck_sync_reg[2];

   // ------------------------------------------------------------------
   // Serial clock divider
   // ------------------------------------------------------------------
   // own clock divider
   always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         div_reg <= '0;
      end else if (div_reg == 2'(`SCB_SCK_HALF - 1)) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_reg + 1'b1;
      end
   end

   assign tick_rise = (div_reg == 2'(`SCB_SCK_HALF - 1)) & ~sck_reg;
   assign tick_fall = (div_reg == 2'(`SCB_SCK_HALF - 1)) & sck_reg;

   // ------------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------------
   always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         st_reg <= ST_IDLE;
         sck_reg <= 1'b0;
         sh_out_reg <= '0;
         bits_reg <= '0;
         wait_reg <= '0;
      end else if (crn_rise) begin
         sck_reg <= 1'b0;
         unique case (mode_reg)
            `SCB_MODE_ACTIVE: begin
               if (multi_sync_reg[1] && width_reg == `SCB_W_X1) begin
                  st_reg <= ST_ERR;
               end else begin
                  st_reg <= ST_WAKE;
                  sh_out_reg <= {`SCB_CMD_WAKE, 24'h_0000_00};
                  bits_reg <= 6'd8;
               end
            end
            `SCB_MODE_PASSIVE: st_reg <= ST_PASS;
            default: st_reg <= ST_PASS;
         endcase
      end else begin
         unique case (st_reg)
            ST_WAKE, ST_CMD: begin
               if (tick_rise) begin
                  sck_reg <= 1'b1;
               end else if (tick_fall) begin
                  sck_reg <= 1'b0;
                  sh_out_reg <= {sh_out_reg[30:0], 1'b0};
                  bits_reg <= bits_reg - 1'b1;
                  if (bits_reg == 6'd1) begin
                     if (st_reg == ST_WAKE) begin
                        st_reg <= ST_WAIT;
                        wait_reg <= 16'(WAKE_CYC);
                     end else begin
                        st_reg <= ST_DUMMY;
                        bits_reg <= 6'(`SCB_DUMMY_BITS);
                     end
                  end
               end
            end
            ST_WAIT: begin
               if (wait_reg != '0) begin
                  wait_reg <= wait_reg - 1'b1;
               end else begin
                  st_reg <= ST_CMD;
                  sh_out_reg <= {`SCB_CMD_FAST, `SCB_ADDR_START};
                  bits_reg <= 6'd32;
               end
            end
            ST_DUMMY: begin
               if (tick_rise) begin
                  sck_reg <= 1'b1;
               end else if (tick_fall) begin
                  sck_reg <= 1'b0;
                  bits_reg <= bits_reg - 1'b1;
                  if (bits_reg == 6'd1) begin
                     st_reg <= ST_DATA;
                  end
               end
            end
            ST_DATA: begin
               if (bytes_reg == 32'(IMAGE_BYTES)) begin
                  st_reg <= ST_DONE;
                  sck_reg <= 1'b0;
               end else if (tick_rise && f_ready) begin
                  sck_reg <= 1'b1;
               end else if (tick_fall) begin
                  sck_reg <= 1'b0;
               end
            end
            ST_PASS: begin
               if (bytes_reg == 32'(IMAGE_BYTES)) begin
                  st_reg <= ST_DONE;
               end
            end
            ST_IDLE, ST_DONE, ST_ERR: begin
               sck_reg <= 1'b0;
            end
            default: st_reg <= ST_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Data capture and byte assembly
   // ------------------------------------------------------------------
   always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         sh_in_reg <= '0;
         nbits_reg <= '0;
         byte_vld_reg <= 1'b0;
         byte_reg <= '0;
      end else begin
         byte_vld_reg <= 1'b0;
         if (crn_rise) begin
            nbits_reg <= '0;
         end else if (st_reg == ST_DATA && tick_rise && f_ready &&
                      bytes_reg != 32'(IMAGE_BYTES)) begin
            unique case (width_reg)
               `SCB_W_X2: sh_in_reg <= {sh_in_reg[5:0], dq_sync2_reg[1:0]};
               `SCB_W_X4: sh_in_reg <= {sh_in_reg[3:0], dq_sync2_reg};
               default: sh_in_reg <= {sh_in_reg[6:0], dq_sync2_reg[1]};
            endcase
            nbits_reg <= nbits_reg + step_bits(width_reg);
         end else if (st_reg == ST_PASS && psck_rise) begin
            sh_in_reg <= {sh_in_reg[6:0], pdat_sync_reg[1]};
            nbits_reg <= nbits_reg + 4'h_1;
         end else if (st_reg == ST_PASS && tv_sync_reg[1] && !tv_prev_reg) begin
            byte_reg <= td_reg;
            byte_vld_reg <= 1'b1;
         end else if (nbits_reg == 4'h_8) begin
            nbits_reg <= '0;
            byte_reg <= sh_in_reg;
            byte_vld_reg <= 1'b1;
         end
      end
   end

   assign in_byte = '{data: byte_reg, valid: byte_vld_reg};

   scb_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .i_clk(I_CLK_SYS),
      .i_reset_n(I_RESET_N),
      .i_in_valid(in_byte.valid),
      .o_in_ready(f_ready),
      .i_in_data(in_byte.data),
      .o_out_valid(f_valid),
      .i_out_ready(I_RAM_READY & ~O_RAM_WE),
      .o_out_data(f_data)
   );

   // ------------------------------------------------------------------
   // Configuration memory write and outputs
   // ------------------------------------------------------------------
   // write configuration memory
   always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         O_RAM_WE <= 1'b0;
         O_RAM_DATA <= '0;
         bytes_reg <= '0;
      end else if (crn_rise) begin
         O_RAM_WE <= 1'b0;
         bytes_reg <= '0;
      end else begin
         O_RAM_WE <= f_valid & I_RAM_READY & ~O_RAM_WE;
         // Count bytes as they enter the buffer so fetching stops in time.
         bytes_reg <= bytes_reg + 32'(byte_vld_reg);
         if (f_valid & I_RAM_READY & ~O_RAM_WE) begin
            O_RAM_DATA <= f_data;
         end
      end
   end

   always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         O_FLASH_SCK <= 1'b0;
         O_FLASH_CS_N <= 1'b1;
         O_FLASH_MOSI <= 1'b0;
         O_FLASH_MOSI_OE_N <= 1'b1;
         O_DONE <= 1'b0;
         O_ERROR <= 1'b0;
      end else begin
         O_FLASH_SCK <= sck_reg;
         O_FLASH_CS_N <= !(st_reg == ST_WAKE || st_reg == ST_CMD ||
                           st_reg == ST_DUMMY || st_reg == ST_DATA);
         O_FLASH_MOSI <= sh_out_reg[31];
         O_FLASH_MOSI_OE_N <= !(st_reg == ST_WAKE || st_reg == ST_CMD);
         O_DONE <= (st_reg == ST_DONE) && !f_valid;
         O_ERROR <= (st_reg == ST_ERR);
      end
   end
endmodule // scb_loader

//--- testbench/scb_loader_sva.sv
/*
 Port checker for the configuration loader.
 Assumes a bind to scb_loader and one system clock domain.
*/
`timescale 1ns/10ps
`include "scb_map.svh"
module scb_loader_sva #(
   parameter int IMAGE_BYTES = 16,
   parameter int WAKE_CYC = `SCB_WAKE_CYC
) (
   input wire logic I_CLK_SYS,
   input wire logic I_RESET_N,
   input wire logic I_CONFIG_RESET_N,
   input wire logic [1:0] I_WIDTH,
   input wire logic I_MULTI_IMAGE,
   input wire logic O_FLASH_SCK,
   input wire logic O_FLASH_CS_N,
   input wire logic O_FLASH_MOSI,
   input wire logic O_FLASH_MOSI_OE_N,
   input wire logic O_RAM_WE,
   input wire logic O_DONE,
   input wire logic O_ERROR
);
   default clocking @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_RESET_N);
   int frm_reg;
   int gap_reg;
   int rc_reg;
   int we_reg;
   logic [31:0] sh_reg;
   // Frame and write counts cleared while a load is held; idle gap and command bits tracked from the flash pins.
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_CONFIG_RESET_N) begin
         frm_reg <= 0;
         we_reg <= 0;
      end else begin
         if ($fell(O_FLASH_CS_N)) frm_reg <= frm_reg + 1;
         if (O_RAM_WE) we_reg <= we_reg + 1;
      end
      gap_reg <= O_FLASH_CS_N ? gap_reg + 1 : 0;
      if (O_FLASH_CS_N) rc_reg <= 0;
      else if ($rose(O_FLASH_SCK)) rc_reg <= rc_reg + 1;
      if ($rose(O_FLASH_SCK)) sh_reg <= {sh_reg[30:0], O_FLASH_MOSI};
   end
   chk_wake_code:
      assert property ($rose(O_FLASH_CS_N) && frm_reg == 1
         |-> sh_reg[7:0] == `SCB_CMD_WAKE) else $error("wake code");
   chk_wake_gap:
      assert property ($fell(O_FLASH_CS_N) && frm_reg == 1
         |-> gap_reg >= WAKE_CYC) else $error("wake gap short");
   chk_read_cmd:
      assert property (frm_reg == 2 && rc_reg == 32
         |-> sh_reg == {`SCB_CMD_FAST, `SCB_ADDR_START})
         else $error("read command");
   chk_sck_rate:
      assert property ($rose(O_FLASH_SCK) |=> O_FLASH_SCK ##1 !O_FLASH_SCK)
         else $error("sck rate");
   chk_drive_frame:
      assert property (!O_FLASH_MOSI_OE_N |-> !O_FLASH_CS_N)
         else $error("mosi outside frame");
   chk_refuse_quiet:
      assert property (O_ERROR |-> O_FLASH_CS_N && !O_RAM_WE)
         else $error("refused load active");
   chk_refuse_why:
      assert property ($rose(O_ERROR)
         |-> I_WIDTH == `SCB_W_X1 && I_MULTI_IMAGE) else $error("bad refuse");
   chk_done_count:
      assert property ($rose(O_DONE)
         |-> we_reg + (O_RAM_WE ? 1 : 0) == IMAGE_BYTES)
         else $error("done count");
   chk_done_excl:
      assert property (!(O_DONE && O_ERROR)) else $error("done with error");
   cover property ($rose(O_DONE));
   cover property ($rose(O_ERROR));
   cover property ($fell(O_FLASH_CS_N) && frm_reg == 1);
endmodule // scb_loader_sva

//--- testbench/scb_flash_model.sv
/*
 Behavioural serial flash answering the loader's fast read.
 Assumes 40 clocks of command, address and dummy before data.
*/
`timescale 1ns/10ps
`include "scb_map.svh"
module scb_flash_model (
   input wire logic i_sck,
   input wire logic i_cs_n,
   input wire logic [1:0] i_width,
   output logic [3:0] o_dq
);
   int n = 0;
   int w;
   int t;
   logic [7:0] b;
   logic [3:0] v;
   initial o_dq = 4'h_5;
   // Undriven lines flip so a stale value never looks valid.
   always @(posedge i_sck or posedge i_cs_n) begin
      n = i_cs_n ? 0 : n + 1;
      if (n < 40) o_dq = ~o_dq;
      else begin
         w = (i_width == `SCB_W_X4) ? 4 : (i_width == `SCB_W_X2) ? 2 : 1;
         v = 4'h_0;
         for (int j = 0; j < w; j++) begin
            t = (n - 40) * w + j;
            b = 8'((t / 8) * 29) ^ 8'h_5A;
            v[w - 1 - j] = b[7 - t % 8];
         end
         o_dq = (w == 1) ? {2'b00, v[0], 1'b0} : v;
      end
   end
endmodule // scb_flash_model

//--- testbench/scb_loader_tb.sv
/*
 Self-checking bench for the configuration loader.
 Assumes the design, the flash model and the checker compiled first.
*/
`timescale 1ns/10ps
`include "scb_map.svh"
module scb_loader_tb;
   localparam int IMG = 12;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic cfg_n = 1'b0;
   logic [1:0] mode = `SCB_MODE_ACTIVE;
   logic [1:0] width = `SCB_W_X4;
   logic multi = 1'b0;
   logic psck = 1'b0;
   logic pdata = 1'b0;
   logic tvalid = 1'b0;
   logic [7:0] tdata = 8'h_00;
   logic ready = 1'b1;
   logic [3:0] dq;
   logic sck, cs_n, mosi, oe_n, we, done, err, cs_seen;
   logic [7:0] wdata;
   logic [7:0] q[$];
   int n_errors = 0;
   int n_tests = 0;
   always #25 clk = ~clk;
   scb_loader #(.IMAGE_BYTES(IMG)) dut_u (
      .I_CLK_SYS(clk), .I_RESET_N(rst_n), .I_CONFIG_RESET_N(cfg_n),
      .I_MODE(mode), .I_WIDTH(width), .I_MULTI_IMAGE(multi),
      .I_FLASH_DQ(dq), .I_PASSIVE_SCK(psck), .I_PASSIVE_DATA(pdata),
      .I_TEST_VALID(tvalid), .I_TEST_DATA(tdata), .I_RAM_READY(ready),
      .O_FLASH_SCK(sck), .O_FLASH_CS_N(cs_n), .O_FLASH_MOSI(mosi),
      .O_FLASH_MOSI_OE_N(oe_n), .O_RAM_WE(we), .O_RAM_DATA(wdata),
      .O_DONE(done), .O_ERROR(err));
   scb_flash_model flash_u (
      .i_sck(sck), .i_cs_n(cs_n), .i_width(width), .o_dq(dq));
   always @(negedge clk) begin
      if (we) q.push_back(wdata);
      if (!cs_n) cs_seen = 1'b1;
   end
   function automatic logic [7:0] pat(int i);
      return 8'(i * 29) ^ 8'h_5A;
   endfunction
   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task automatic results();
      if (n_errors == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic start(logic [1:0] m, logic [1:0] w, logic mi);
      @(negedge clk);
      mode = m;
      width = w;
      multi = mi;
      cfg_n = 1'b0;
      q.delete();
      cs_seen = 1'b0;
      repeat (10) @(negedge clk);
      cfg_n = 1'b1;
      // Let the restart clear the previous done or error level.
      repeat (5) @(negedge clk);
   endtask
   task automatic finish(logic e, int nb);
      int k;
      for (k = 0; k < 20000 && !(done || err); k++) @(negedge clk);
      if (k == 20000) begin
         n_errors++;
         $display("[ERR] load end expected 1 seen 0");
         results();
      end
      repeat (20) @(negedge clk);
      check("error", err, e);
      check("done", done, !e);
      check("bytes", q.size(), nb);
      for (int i = 0; i < q.size(); i++) check("data", q[i], pat(i));
   endtask
   task automatic t_active(logic [1:0] w, logic mi);
      start(`SCB_MODE_ACTIVE, w, mi);
      ready = 1'b0;
      repeat (1400) @(negedge clk);
      ready = 1'b1;
      finish(1'b0, IMG);
      check("flash used", cs_seen, 1'b1);
   endtask
   task automatic t_refuse();
      start(`SCB_MODE_ACTIVE, `SCB_W_X1, 1'b1);
      finish(1'b1, 0);
      check("flash idle", cs_seen, 1'b0);
   endtask
   task automatic t_passive();
      logic [7:0] b;
      start(`SCB_MODE_PASSIVE, `SCB_W_X1, 1'b0);
      repeat (20) @(negedge clk);
      for (int i = 0; i < IMG * 8; i++) begin
         b = pat(i / 8);
         pdata = b[7 - i % 8];
         repeat (4) @(negedge clk);
         psck = 1'b1;
         repeat (4) @(negedge clk);
         psck = 1'b0;
      end
      pdata = ~pdata;
      finish(1'b0, IMG);
   endtask
   task automatic t_test();
      start(`SCB_MODE_JTAG, `SCB_W_X1, 1'b0);
      for (int i = 0; i < IMG; i++) begin
         tdata = pat(i);
         repeat (3) @(negedge clk);
         tvalid = 1'b1;
         repeat (3) @(negedge clk);
         tvalid = 1'b0;
      end
      finish(1'b0, IMG);
   endtask
   initial begin
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      t_active(`SCB_W_X4, 1'b1);
      t_active(`SCB_W_X2, 1'b0);
      t_refuse();
      t_passive();
      t_test();
      results();
   end
endmodule // scb_loader_tb
bind scb_loader scb_loader_sva #(
   .IMAGE_BYTES(IMAGE_BYTES), .WAKE_CYC(WAKE_CYC)) chk_u (
   .I_CLK_SYS(I_CLK_SYS), .I_RESET_N(I_RESET_N),
   .I_CONFIG_RESET_N(I_CONFIG_RESET_N), .I_WIDTH(I_WIDTH),
   .I_MULTI_IMAGE(I_MULTI_IMAGE), .O_FLASH_SCK(O_FLASH_SCK),
   .O_FLASH_CS_N(O_FLASH_CS_N), .O_FLASH_MOSI(O_FLASH_MOSI),
   .O_FLASH_MOSI_OE_N(O_FLASH_MOSI_OE_N), .O_RAM_WE(O_RAM_WE),
   .O_DONE(O_DONE), .O_ERROR(O_ERROR));
